// file: src/abse_alu.sv
/*
  Combinational datapath for add, AND, bit clear/set and bit test.
  Assumes the caller supplies the accumulator and the addressed file value.
*/
`timescale 1ns/100ps
module abse_alu
(
  input wire abse_pkg::abse_cmd_t cmd,
  input wire logic [7:0] accum,
  input wire logic [7:0] file_val,
  output abse_pkg::abse_alu_out_t alu_out
);

  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] nib_sum;
  logic [7:0] mask;
  logic tested;

  always_comb
  begin
    alu_out = '0;
    operand = (cmd.op == abse_pkg::ABSE_OP_ADD_LITERAL_TO_ACCUMULATOR ||
               cmd.op == abse_pkg::ABSE_OP_AND_LITERAL_INTO_ACCUMULATOR) ?
              cmd.literal : file_val;
    // carry from bit 7, digit carry from bit 3
    sum = {1'b0, accum} + {1'b0, operand};
    nib_sum = {1'b0, accum[3:0]} + {1'b0, operand[3:0]};
    mask = 8'h01 << cmd.bit_sel;
    tested = |(file_val & mask);
    unique case (cmd.op)
      abse_pkg::ABSE_OP_ADD_LITERAL_TO_ACCUMULATOR:
      begin
        alu_out.result = sum[7:0];
        alu_out.upd_carry = 1'b1;
        alu_out.upd_zero = 1'b1;
        alu_out.to_accum = 1'b1;
      end
      abse_pkg::ABSE_OP_ADD_ACCUMULATOR_TO_FILE:
      begin
        alu_out.result = sum[7:0];
        alu_out.upd_carry = 1'b1;
        alu_out.upd_zero = 1'b1;
        alu_out.to_accum = ~cmd.dest;
        alu_out.to_file = cmd.dest;
      end
      abse_pkg::ABSE_OP_FILE_BIT_CLEAR:
      begin
        alu_out.result = file_val & ~mask;
        alu_out.to_file = 1'b1;
      end
      abse_pkg::ABSE_OP_FILE_BIT_SET:
      begin
        alu_out.result = file_val | mask;
        alu_out.to_file = 1'b1;
      end
      abse_pkg::ABSE_OP_AND_LITERAL_INTO_ACCUMULATOR:
      begin
        alu_out.result = accum & operand;
        alu_out.upd_zero = 1'b1;
        alu_out.to_accum = 1'b1;
      end
      abse_pkg::ABSE_OP_AND_ACCUMULATOR_WITH_FILE:
      begin
        alu_out.result = accum & operand;
        alu_out.upd_zero = 1'b1;
        alu_out.to_accum = ~cmd.dest;
        alu_out.to_file = cmd.dest;
      end
      abse_pkg::ABSE_OP_TEST_BIT_SKIP_WHEN_ONE:
        alu_out.skip = tested;
      abse_pkg::ABSE_OP_TEST_BIT_SKIP_WHEN_ZERO:
        alu_out.skip = ~tested;
      // No-operation and unused codes change nothing
      default:
        alu_out.result = 8'h00;
    endcase
    alu_out.flags.c = sum[8];
    alu_out.flags.dc = nib_sum[4];
    alu_out.flags.z = (alu_out.result == 8'h00);
  end

endmodule

// file: src/abse_exec.sv
/*
  Execution block for add, AND, bit clear/set and bit test with skip,
  reached as an AXI4-Lite slave. One full-strobe command word written is one
  instruction cycle.
  Assumes a single AXI4-Lite master, one write and one read at a time.
*/
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module abse_exec
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    abse_pkg::abse_wr_state_t wst;
    logic aw_got;
    logic w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] accum;
    abse_pkg::abse_flags_t flags;
    logic skip_pending;
    logic [31:0] cycles;
  } abse_state_t;

  localparam abse_state_t ABSE_STATE_RST = '{
    wst: abse_pkg::ABSE_WR_IDLE,
    aw_got: 1'b0,
    w_got: 1'b0,
    waddr: 12'h000,
    wdata: 32'h0000_0000,
    wstrb: 4'h0,
    bresp: abse_pkg::ABSE_RESP_OKAY,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: abse_pkg::ABSE_RESP_OKAY,
    accum: abse_pkg::ABSE_ACCUM_RST,
    flags: abse_pkg::ABSE_FLAGS_RST,
    skip_pending: 1'b0,
    cycles: abse_pkg::ABSE_CYCLES_RST
  };

  abse_state_t s_reg;
  abse_state_t s_next;

  abse_pkg::abse_cmd_t cmd;
  abse_pkg::abse_alu_out_t alu_out;
  abse_pkg::abse_region_t wr_region;
  abse_pkg::abse_region_t rd_region;
  logic [7:0] exec_file_val;
  logic [7:0] rd_file_val;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic do_write;

  // Unused protection bits
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  assign cmd = abse_pkg::abse_decode_cmd(s_reg.wdata);
  assign wr_region = abse_pkg::abse_region(s_reg.waddr);
  assign rd_region = abse_pkg::abse_region(s_axi_araddr);
  assign do_write = (s_reg.wst == abse_pkg::ABSE_WR_IDLE) && s_reg.aw_got && s_reg.w_got;

  abse_alu u_alu
  (
    .cmd(cmd),
    .accum(s_reg.accum),
    .file_val(exec_file_val),
    .alu_out(alu_out)
  );

  abse_file_mem
  #(
    .DEPTH(abse_pkg::ABSE_FILE_DEPTH),
    .WIDTH(8),
    .AW(abse_pkg::ABSE_FILE_AW)
  )
  u_file_mem
  (
    .aclk(aclk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_a_addr(cmd.file_addr),
    .rd_a_data(exec_file_val),
    .rd_b_addr(s_axi_araddr[8:2]),
    .rd_b_data(rd_file_val)
  );

  assign s_axi_awready = (s_reg.wst == abse_pkg::ABSE_WR_IDLE) && !s_reg.aw_got;
  assign s_axi_wready = (s_reg.wst == abse_pkg::ABSE_WR_IDLE) && !s_reg.w_got;
  assign s_axi_bvalid = (s_reg.wst == abse_pkg::ABSE_WR_RESP);
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  always_comb
  begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_waddr = s_reg.waddr[8:2];
    mem_wdata = s_reg.wdata[7:0];

    unique case (s_reg.wst)
      abse_pkg::ABSE_WR_IDLE:
      begin
        // Address and data may arrive in either order
        if (s_axi_awvalid && !s_reg.aw_got)
        begin
          s_next.aw_got = 1'b1;
          s_next.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_got)
        begin
          s_next.w_got = 1'b1;
          s_next.wdata = s_axi_wdata;
          s_next.wstrb = s_axi_wstrb;
        end
        if (do_write)
        begin
          s_next.aw_got = 1'b0;
          s_next.w_got = 1'b0;
          s_next.wst = abse_pkg::ABSE_WR_RESP;
          s_next.bresp = abse_pkg::ABSE_RESP_OKAY;
          unique case (wr_region)
            abse_pkg::ABSE_REG_COMMAND:
            begin
              // Partial command words would execute half a field: ignored
              if (s_reg.wstrb == 4'hF)
              begin
                s_next.cycles = s_reg.cycles + 32'h0000_0001;
                if (s_reg.skip_pending)
                begin
                  s_next.skip_pending = 1'b0;
                end
                else
                begin
                  if (alu_out.to_accum)
                    s_next.accum = alu_out.result;
                  mem_we = alu_out.to_file;
                  mem_waddr = cmd.file_addr;
                  mem_wdata = alu_out.result;
                  // flags only where the operation owns them
                  if (alu_out.upd_carry)
                  begin
                    s_next.flags.c = alu_out.flags.c;
                    s_next.flags.dc = alu_out.flags.dc;
                  end
                  if (alu_out.upd_zero)
                    s_next.flags.z = alu_out.flags.z;
                  // arm the skip of the next slot
                  s_next.skip_pending = alu_out.skip;
                end
              end
            end
            abse_pkg::ABSE_REG_STATUS:
            begin
              if (s_reg.wstrb[0])
              begin
                s_next.flags.c = s_reg.wdata[abse_pkg::ABSE_ST_C_POS];
                s_next.flags.dc = s_reg.wdata[abse_pkg::ABSE_ST_DC_POS];
                s_next.flags.z = s_reg.wdata[abse_pkg::ABSE_ST_Z_POS];
              end
            end
            abse_pkg::ABSE_REG_ACCUM:
            begin
              if (s_reg.wstrb[0])
                s_next.accum = s_reg.wdata[7:0];
            end
            abse_pkg::ABSE_REG_CYCLES:
              s_next.bresp = abse_pkg::ABSE_RESP_OKAY;
            abse_pkg::ABSE_REG_FILE:
              mem_we = s_reg.wstrb[0];
            abse_pkg::ABSE_REG_NONE:
              s_next.bresp = abse_pkg::ABSE_RESP_DECERR;
          endcase
        end
      end
      abse_pkg::ABSE_WR_RESP:
      begin
        if (s_axi_bready)
          s_next.wst = abse_pkg::ABSE_WR_IDLE;
      end
      default:
        s_next.wst = abse_pkg::ABSE_WR_IDLE;
    endcase

    if (!s_reg.rvalid && s_axi_arvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h0000_0000;
      s_next.rresp = abse_pkg::ABSE_RESP_OKAY;
      unique case (rd_region)
        abse_pkg::ABSE_REG_COMMAND:
          s_next.rdata = 32'h0000_0000;
        abse_pkg::ABSE_REG_STATUS:
        begin
          s_next.rdata[abse_pkg::ABSE_ST_C_POS] = s_reg.flags.c;
          s_next.rdata[abse_pkg::ABSE_ST_DC_POS] = s_reg.flags.dc;
          s_next.rdata[abse_pkg::ABSE_ST_Z_POS] = s_reg.flags.z;
          s_next.rdata[abse_pkg::ABSE_ST_SKIP_POS] = s_reg.skip_pending;
        end
        abse_pkg::ABSE_REG_ACCUM:
          s_next.rdata[7:0] = s_reg.accum;
        abse_pkg::ABSE_REG_CYCLES:
          s_next.rdata = s_reg.cycles;
        abse_pkg::ABSE_REG_FILE:
          s_next.rdata[7:0] = rd_file_val;
        abse_pkg::ABSE_REG_NONE:
          s_next.rresp = abse_pkg::ABSE_RESP_DECERR;
      endcase
    end
    else if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= ABSE_STATE_RST;
    else
      s_reg <= s_next;
  end

endmodule

// file: src/abse_file_mem.sv
/*
  File register array: one write port, two combinational read ports.
  Assumes a single writer per cycle; contents are not reset.
*/
`timescale 1ns/100ps
module abse_file_mem
#(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW = $clog2(DEPTH)
)
(
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_a_addr,
  output logic [WIDTH-1:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [WIDTH-1:0] rd_b_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Left unreset so it can map onto plain RAM
  always_ff @(posedge aclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  assign rd_a_data = mem[rd_a_addr];
  assign rd_b_data = mem[rd_b_addr];

endmodule

// file: src/abse_pkg.sv
/*
  Constants, command encodings and carrier types for the add, AND and
  bit-skip execution block.
  Assumes an AXI4-Lite master with 32-bit data and a 12-bit byte address.
*/
// Operation
// - Add-literal adds an 8-bit literal into the accumulator and updates C, DC and Z.
// - Add-file sums accumulator and file; dest 0 writes the accumulator, dest 1 the file.
// - Bit-clear forces one bit of a file register to 0; other bits and all flags stay.
// - Bit-set forces one bit of a file register to 1; other bits and all flags stay.
// - AND-literal ANDs a literal into the accumulator and updates only Z.
// - AND-file ANDs accumulator and file into the chosen destination and updates only Z.
// - Skip-when-one turns the next instruction into a no-operation when the bit is 1.
// - Skip-when-zero turns the next instruction into a no-operation when the bit is 0.
package abse_pkg;

  localparam int unsigned ABSE_ADDR_W = 12;
  localparam int unsigned ABSE_DATA_W = 32;
  localparam int unsigned ABSE_FILE_DEPTH = 128;
  localparam int unsigned ABSE_FILE_AW = 7;

  // Byte offsets
  localparam logic [11:0] ABSE_OFF_COMMAND = 12'h000;
  localparam logic [11:0] ABSE_OFF_STATUS = 12'h004;
  localparam logic [11:0] ABSE_OFF_ACCUM = 12'h008;
  localparam logic [11:0] ABSE_OFF_CYCLES = 12'h00C;
  // File window: 0x200 + 4 * file address
  localparam logic [2:0] ABSE_FILE_WIN_TAG = 3'h1;

  // Command word fields
  localparam int unsigned ABSE_CMD_LIT_LSB = 0;
  localparam int unsigned ABSE_CMD_ADDR_LSB = 8;
  localparam int unsigned ABSE_CMD_BIT_LSB = 16;
  localparam int unsigned ABSE_CMD_DEST_POS = 20;
  localparam int unsigned ABSE_CMD_OP_LSB = 24;

  // Status register bits
  localparam int unsigned ABSE_ST_C_POS = 0;
  localparam int unsigned ABSE_ST_DC_POS = 1;
  localparam int unsigned ABSE_ST_Z_POS = 2;
  localparam int unsigned ABSE_ST_SKIP_POS = 3;

  // Reset values
  localparam logic [7:0] ABSE_ACCUM_RST = 8'h00;
  localparam logic [2:0] ABSE_FLAGS_RST = 3'h0;
  localparam logic [31:0] ABSE_CYCLES_RST = 32'h0000_0000;

  localparam logic [1:0] ABSE_RESP_OKAY = 2'h0;
  localparam logic [1:0] ABSE_RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    ABSE_OP_NOP = 4'h0,
    ABSE_OP_ADD_LITERAL_TO_ACCUMULATOR = 4'h1,
    ABSE_OP_ADD_ACCUMULATOR_TO_FILE = 4'h2,
    ABSE_OP_FILE_BIT_CLEAR = 4'h3,
    ABSE_OP_FILE_BIT_SET = 4'h4,
    ABSE_OP_AND_LITERAL_INTO_ACCUMULATOR = 4'h5,
    ABSE_OP_AND_ACCUMULATOR_WITH_FILE = 4'h6,
    ABSE_OP_TEST_BIT_SKIP_WHEN_ONE = 4'h7,
    ABSE_OP_TEST_BIT_SKIP_WHEN_ZERO = 4'h8
  } abse_op_t;

  typedef enum logic [1:0] {
    ABSE_WR_IDLE = 2'b01,
    ABSE_WR_RESP = 2'b10
  } abse_wr_state_t;

  typedef enum logic [2:0] {
    ABSE_REG_NONE,
    ABSE_REG_COMMAND,
    ABSE_REG_STATUS,
    ABSE_REG_ACCUM,
    ABSE_REG_CYCLES,
    ABSE_REG_FILE
  } abse_region_t;

  typedef struct packed {
    logic [3:0] op;
    logic dest;
    logic [2:0] bit_sel;
    logic [6:0] file_addr;
    logic [7:0] literal;
  } abse_cmd_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } abse_flags_t;

  typedef struct packed {
    logic [7:0] result;
    abse_flags_t flags;
    logic upd_carry;
    logic upd_zero;
    logic to_accum;
    logic to_file;
    logic skip;
  } abse_alu_out_t;

  function automatic abse_cmd_t abse_decode_cmd(input logic [31:0] word);
    abse_cmd_t c;
    c.op = word[ABSE_CMD_OP_LSB +: 4];
    c.dest = word[ABSE_CMD_DEST_POS];
    c.bit_sel = word[ABSE_CMD_BIT_LSB +: 3];
    c.file_addr = word[ABSE_CMD_ADDR_LSB +: 7];
    c.literal = word[ABSE_CMD_LIT_LSB +: 8];
    return c;
  endfunction

  function automatic abse_region_t abse_region(input logic [11:0] addr);
    abse_region_t r;
    r = ABSE_REG_NONE;
    if (addr[11:9] == ABSE_FILE_WIN_TAG)
      r = ABSE_REG_FILE;
    else if (addr[11:2] == ABSE_OFF_COMMAND[11:2])
      r = ABSE_REG_COMMAND;
    else if (addr[11:2] == ABSE_OFF_STATUS[11:2])
      r = ABSE_REG_STATUS;
    else if (addr[11:2] == ABSE_OFF_ACCUM[11:2])
      r = ABSE_REG_ACCUM;
    else if (addr[11:2] == ABSE_OFF_CYCLES[11:2])
      r = ABSE_REG_CYCLES;
    return r;
  endfunction

endpackage

// file: verification/abse_exec_chk.sv
/*
  Checker for the AXI4-Lite slave port of the execution block.
  Assumes one clock and a synchronous active-low reset; bound below.
*/
`timescale 1ns/100ps
module abse_exec_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer timing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken early");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken early");

  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_dec: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule

bind abse_exec abse_exec_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// file: verification/tb.sv
/*
  Self-checking bench: AXI4-Lite tasks write command words and read back
  accumulator, status, cycle count and file registers.
  Assumes the register map and command layout of abse_pkg.
*/
`timescale 1ns/100ps
module tb;
  localparam logic [11:0] CM = abse_pkg::ABSE_OFF_COMMAND;
  localparam logic [11:0] ST = abse_pkg::ABSE_OFF_STATUS;
  localparam logic [11:0] AC = abse_pkg::ABSE_OFF_ACCUM;
  localparam logic [11:0] CY = abse_pkg::ABSE_OFF_CYCLES;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int fails, checks_done, ncmd;
  logic [3:0] sop [4];
  logic [2:0] sbit [4];
  logic sk [4];

  abse_exec DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw, gb;
    logic [1:0] gr;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Partial-strobe command words are not instruction cycles
    if (a == CM && wstrb == 4'hF)
      ncmd++;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ga = awvalid && awready;
      gw = wvalid && wready;
      gb = bvalid;
      gr = bresp;
      @(posedge aclk);
      if (ga)
        awvalid <= 1'b0;
      if (gw)
        wvalid <= 1'b0;
      if (gb)
      begin
        bready <= 1'b0;
        chk({30'h0, gr}, {30'h0, er});
        return;
      end
    end
    fails++;
    end_of_test();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ga;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ga = arvalid && arready;
      if (rvalid)
      begin
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
        rready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (ga)
        arvalid <= 1'b0;
    end
    fails++;
    end_of_test();
  endtask

  task automatic x(input logic [3:0] op, input logic d, input logic [2:0] b,
    input logic [6:0] f, input logic [7:0] k);
    wr(CM, {4'h0, op, 3'h0, d, 1'h0, b, 1'h0, f, k}, 2'h0);
  endtask

  function automatic logic [11:0] fa(input int n);
    return 12'h200 + 12'(n * 4);
  endfunction

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    sop = '{4'h7, 4'h7, 4'h8, 4'h8};
    sbit = '{3'h2, 3'h1, 3'h1, 3'h2};
    sk = '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(AC, 32'h0, 2'h0);
    rd(ST, 32'h0, 2'h0);
    rd(CY, 32'h0, 2'h0);
    wr(12'h010, 32'h1, 2'h3);
    rd(12'h010, 32'h0, 2'h3);
    // Carry out of both nibbles with a zero sum
    wr(AC, 32'h8F, 2'h0);
    x(4'h1, 1'b0, 3'h0, 7'h00, 8'h71);
    rd(AC, 32'h00, 2'h0);
    rd(ST, 32'h7, 2'h0);
    x(4'h1, 1'b0, 3'h0, 7'h00, 8'hFF);
    rd(AC, 32'hFF, 2'h0);
    rd(ST, 32'h0, 2'h0);
    wr(fa(127), 32'h0F, 2'h0);
    wr(AC, 32'h01, 2'h0);
    x(4'h2, 1'b1, 3'h0, 7'h7F, 8'h00);
    rd(fa(127), 32'h10, 2'h0);
    rd(AC, 32'h01, 2'h0);
    rd(ST, 32'h2, 2'h0);
    wr(AC, 32'hF0, 2'h0);
    x(4'h2, 1'b0, 3'h0, 7'h7F, 8'h00);
    rd(AC, 32'h00, 2'h0);
    rd(fa(127), 32'h10, 2'h0);
    rd(ST, 32'h5, 2'h0);
    wr(ST, 32'h3, 2'h0);
    wr(AC, 32'h3C, 2'h0);
    x(4'h5, 1'b0, 3'h0, 7'h00, 8'hC3);
    rd(AC, 32'h00, 2'h0);
    rd(ST, 32'h7, 2'h0);
    wr(fa(0), 32'hF0, 2'h0);
    wr(AC, 32'h3C, 2'h0);
    x(4'h6, 1'b1, 3'h0, 7'h00, 8'h00);
    rd(fa(0), 32'h30, 2'h0);
    rd(AC, 32'h3C, 2'h0);
    rd(ST, 32'h3, 2'h0);
    wr(AC, 32'hC3, 2'h0);
    x(4'h6, 1'b0, 3'h0, 7'h00, 8'h00);
    rd(AC, 32'h00, 2'h0);
    rd(ST, 32'h7, 2'h0);
    // Set every bit position from 0 to 7, then clear them from 0 to 7
    wr(fa(5), 32'h00, 2'h0);
    for (int b = 0; b < 8; b++)
    begin
      x(4'h4, 1'b0, 3'(b), 7'h05, 8'h00);
      rd(fa(5), (32'h2 << b) - 32'h1, 2'h0);
    end
    for (int b = 0; b < 8; b++)
    begin
      x(4'h3, 1'b0, 3'(b), 7'h05, 8'hFF);
      rd(fa(5), (32'hFF << (b + 1)) & 32'hFF, 2'h0);
    end
    rd(ST, 32'h7, 2'h0);
    // Each test followed by an add that must run only when not skipped
    wr(fa(1), 32'h04, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ST, 32'h7, 2'h0);
      wr(AC, 32'h00, 2'h0);
      x(sop[i], 1'b0, sbit[i], 7'h01, 8'h00);
      rd(ST, sk[i] ? 32'hF : 32'h7, 2'h0);
      x(4'h1, 1'b0, 3'h0, 7'h00, 8'h01);
      rd(AC, sk[i] ? 32'h0 : 32'h1, 2'h0);
      rd(ST, sk[i] ? 32'h7 : 32'h0, 2'h0);
    end
    // Idle and unused codes leave accumulator, file and flags alone
    wr(AC, 32'h5A, 2'h0);
    x(4'h0, 1'b0, 3'h0, 7'h00, 8'h11);
    x(4'hF, 1'b1, 3'h0, 7'h01, 8'h11);
    rd(AC, 32'h5A, 2'h0);
    rd(fa(1), 32'h04, 2'h0);
    rd(ST, 32'h0, 2'h0);
    rd(CM, 32'h0, 2'h0);
    wr(CY, 32'h55, 2'h0);
    // A partial command word must neither run nor use up the skip
    x(4'h7, 1'b0, 3'h2, 7'h01, 8'h00);
    rd(ST, 32'h8, 2'h0);
    wstrb <= 4'h7;
    x(4'h1, 1'b0, 3'h0, 7'h00, 8'h01);
    wstrb <= 4'hF;
    rd(ST, 32'h8, 2'h0);
    rd(AC, 32'h5A, 2'h0);
    rd(CY, ncmd, 2'h0);
    // Reset in mid-run clears accumulator, flags, pending skip and count
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(AC, 32'h0, 2'h0);
    rd(ST, 32'h0, 2'h0);
    rd(CY, 32'h0, 2'h0);
    end_of_test();
  end
endmodule
